// File: logic/iofr_input_map.sv
`timescale 1ns/100ps
`default_nettype none
// Terminals 7..11 to internal functions, combinational
module iofr_input_map (
  input wire iofr_pkg::iofr_mode_t mode,
  input wire logic [2:0] in_set,
  input wire logic [4:0] term_in,
  output logic servo_on,
  output logic fwd_inhibit,
  output logic rev_inhibit,
  output logic fwd_enable,
  output logic rev_enable,
  output logic counter_clear,
  output logic fault_clear_request,
  output logic deviation_counter_clear,
  output logic speed_limit_req,
  output logic current_limit_req,
  output logic cmd_source_sel
);
  import iofr_pkg::*;

  logic t7, t8, t9, t10, t11;
  assign {t11, t10, t9, t8, t7} = term_in;

  always_comb begin
    servo_on = t7;
    fwd_inhibit = 1'b0;
    rev_inhibit = 1'b0;
    fwd_enable = 1'b0;
    rev_enable = 1'b0;
    counter_clear = 1'b0;
    fault_clear_request = 1'b0;
    deviation_counter_clear = 1'b0;
    speed_limit_req = 1'b0;
    current_limit_req = 1'b0;
    cmd_source_sel = 1'b0;
    unique case (mode)
      IOFR_MODE_POS: begin
        if (in_set == 3'h3) begin
          fault_clear_request = t8;
          deviation_counter_clear = t9;
          speed_limit_req = t10;
          current_limit_req = t11;
        end else begin
          fwd_inhibit = t8;
          rev_inhibit = t9;
          unique case (in_set)
            3'h1: begin
              counter_clear = t10;
              speed_limit_req = t11;
            end
            3'h2: begin
              counter_clear = t10;
              current_limit_req = t11;
            end
            default: begin
              fault_clear_request = t10;
              deviation_counter_clear = t11;
            end
          endcase
        end
      end
      IOFR_MODE_SPD: begin
        fwd_enable = t8;
        rev_enable = t9;
        unique case (in_set)
          3'h1: begin
            fault_clear_request = t10;
            current_limit_req = t11;
          end
          3'h2: begin
            speed_limit_req = t10;
            current_limit_req = t11;
          end
          3'h3: begin
            fault_clear_request = t10;
            cmd_source_sel = t11;
          end
          3'h4: begin
            cmd_source_sel = t10;
            speed_limit_req = t11;
          end
          3'h5: begin
            cmd_source_sel = t10;
            current_limit_req = t11;
          end
          default: begin
            fault_clear_request = t10;
            speed_limit_req = t11;
          end
        endcase
      end
      default: begin
        fwd_enable = t8;
        rev_enable = t9;
        unique case (in_set)
          3'h1: begin
            fault_clear_request = t10;
            cmd_source_sel = t11;
          end
          3'h2: begin
            cmd_source_sel = t10;
            current_limit_req = t11;
          end
          default: begin
            fault_clear_request = t10;
            current_limit_req = t11;
          end
        endcase
      end
    endcase
  end

endmodule : iofr_input_map
`default_nettype wire

// File: logic/iofr_pkg.sv
// What this block does
// - All discrete control and status pass through one connector's terminals.
// - Input assignment parameter 11 selects input routing per control mode.
// - Output assignment parameter 12 selects output routing per control mode.
// - Both assignment parameters reset to setting 0 in every mode.
// - Position inputs 0-3: 7-9 servo/inhibits except setting 3 (8-11 clears/limits); 10/11 vary by setting.
// - Speed inputs 0-5: 7-9 servo/enables; 10/11 from six-entry table.
// - Torque inputs 0-2: 7-9 servo/enables; 10/11 from three-entry table.
// - Position outputs 1,2,5 fixed; 3/4 from three-entry table.
// - Speed outputs 1,2,5 fixed; 3/4 from three-entry table.
// - Torque output setting 0 only; outputs 1-4 fixed.
// - In-position asserted while deviation count below parameter 22 range.
// - Alarm output normally closed: on in normal operation, off on alarm.
package iofr_pkg;

  typedef enum logic [1:0] {
    IOFR_MODE_POS,
    IOFR_MODE_SPD,
    IOFR_MODE_TRQ
  } iofr_mode_t;

  localparam int IOFR_ADDR_W = 12;
  localparam int IOFR_DEV_W = 24;

  // Register byte offsets
  localparam logic [11:0] IOFR_OFS_CTRL = 12'h000;
  localparam logic [11:0] IOFR_OFS_INPOS = 12'h004;
  localparam logic [11:0] IOFR_OFS_TERM = 12'h008;
  localparam logic [11:0] IOFR_OFS_FUNC = 12'h00c;

  // CTRL fields
  localparam int IOFR_CTRL_IN_LSB = 0;
  localparam int IOFR_CTRL_OUT_LSB = 4;
  localparam int IOFR_CTRL_MODE_LSB = 8;

  // Reset values
  localparam logic [2:0] IOFR_IN_SET_RST = 3'h0;
  localparam logic [1:0] IOFR_OUT_SET_RST = 2'h0;
  localparam logic [23:0] IOFR_INPOS_RST = 24'h00000a;

  // Highest legal setting per mode
  localparam logic [2:0] IOFR_IN_MAX_POS = 3'h3;
  localparam logic [2:0] IOFR_IN_MAX_SPD = 3'h5;
  localparam logic [2:0] IOFR_IN_MAX_TRQ = 3'h2;
  localparam logic [1:0] IOFR_OUT_MAX_PS = 2'h2;
  localparam logic [1:0] IOFR_OUT_MAX_TRQ = 2'h0;

endpackage : iofr_pkg

// File: logic/iofr_router.sv
`timescale 1ns/100ps
`default_nettype none
module iofr_router #(
  parameter int DEV_W = iofr_pkg::IOFR_DEV_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [iofr_pkg::IOFR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] term_in,
  output logic [4:0] term_out,
  input wire logic [DEV_W-1:0] deviation_count,
  input wire logic speed_attained,
  input wire logic alarm_active,
  input wire logic op_ready,
  input wire logic speed_limited_flag,
  input wire logic current_limited_flag,
  input wire logic enc_index,
  output logic servo_on,
  output logic fwd_inhibit,
  output logic rev_inhibit,
  output logic fwd_enable,
  output logic rev_enable,
  output logic counter_clear,
  output logic fault_clear_request,
  output logic deviation_counter_clear,
  output logic speed_limit_req,
  output logic current_limit_req,
  output logic cmd_source_sel
);
  import iofr_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers

  logic [2:0] in_set_q, in_set_d;
  logic [1:0] out_set_q, out_set_d;
  iofr_mode_t mode_q, mode_d;
  logic [DEV_W-1:0] inpos_q, inpos_d;
  logic [31:0] prdata_q, prdata_d;
  logic pslverr_q, pslverr_d;
  logic pready_q, pready_d;
  logic [4:0] term_out_d, term_out_q;

  logic access;
  logic commit;
  logic addr_ok;
  logic wr_ok;
  logic [2:0] wr_in;
  logic [1:0] wr_out;
  logic [1:0] wr_mode;
  logic [10:0] func_vec;

  function automatic logic in_legal(logic [1:0] m, logic [2:0] s);
    unique case (m)
      2'h0: in_legal = (s <= IOFR_IN_MAX_POS);
      2'h1: in_legal = (s <= IOFR_IN_MAX_SPD);
      2'h2: in_legal = (s <= IOFR_IN_MAX_TRQ);
      default: in_legal = 1'b0;
    endcase
  endfunction : in_legal

  function automatic logic out_legal(logic [1:0] m, logic [1:0] s);
    if (m == 2'h2) begin
      out_legal = (s <= IOFR_OUT_MAX_TRQ);
    end else begin
      out_legal = (s <= IOFR_OUT_MAX_PS);
    end
  endfunction : out_legal

  assign access = psel && penable && !pready_q;
  // Completing edge of a write: pready sampled high with the request
  assign commit = psel && penable && pready_q && pwrite;
  assign addr_ok = (paddr == IOFR_OFS_CTRL) || (paddr == IOFR_OFS_INPOS)
                   || (paddr == IOFR_OFS_TERM) || (paddr == IOFR_OFS_FUNC);
  assign wr_in = pwdata[IOFR_CTRL_IN_LSB +: 3];
  assign wr_out = pwdata[IOFR_CTRL_OUT_LSB +: 2];
  assign wr_mode = pwdata[IOFR_CTRL_MODE_LSB +: 2];
  // Illegal combinations refused whole, settings kept
  assign wr_ok = in_legal(wr_mode, wr_in) && out_legal(wr_mode, wr_out);

  always_comb begin
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    pready_d = access;
    if (access) begin
      pslverr_d = !addr_ok;
      prdata_d = 32'h0000_0000;
      if (pwrite) begin
        if ((paddr == IOFR_OFS_CTRL) && !wr_ok) begin
          pslverr_d = 1'b1;
        end else if ((paddr == IOFR_OFS_TERM)
                     || (paddr == IOFR_OFS_FUNC)) begin
          // Status words are read only
          pslverr_d = 1'b1;
        end
      end else begin
        unique case (paddr)
          IOFR_OFS_CTRL: begin
            prdata_d[IOFR_CTRL_IN_LSB +: 3] = in_set_q;
            prdata_d[IOFR_CTRL_OUT_LSB +: 2] = out_set_q;
            prdata_d[IOFR_CTRL_MODE_LSB +: 2] = mode_q;
          end
          IOFR_OFS_INPOS: prdata_d[DEV_W-1:0] = inpos_q;
          IOFR_OFS_TERM: prdata_d[9:0] = {term_out_q, term_in};
          IOFR_OFS_FUNC: prdata_d[10:0] = func_vec;
          default: prdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      pready_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
      pready_q <= pready_d;
    end
  end

  // Settings change only at the edge that completes the write
  always_comb begin
    in_set_d = in_set_q;
    out_set_d = out_set_q;
    mode_d = mode_q;
    inpos_d = inpos_q;
    if (commit && (paddr == IOFR_OFS_CTRL) && wr_ok) begin
      in_set_d = wr_in;
      out_set_d = wr_out;
      mode_d = iofr_mode_t'(wr_mode);
    end
    if (commit && (paddr == IOFR_OFS_INPOS)) begin
      inpos_d = pwdata[DEV_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_set_q <= IOFR_IN_SET_RST;
      out_set_q <= IOFR_OUT_SET_RST;
      mode_q <= IOFR_MODE_POS;
      inpos_q <= IOFR_INPOS_RST[DEV_W-1:0];
    end else begin
      in_set_q <= in_set_d;
      out_set_q <= out_set_d;
      mode_q <= mode_d;
      inpos_q <= inpos_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  ////////////////////////////////////////////////////////////////////////
  // Input routing

  logic [10:0] fn_d, fn_q;

  iofr_input_map u_in_map (
    .mode(mode_q),
    .in_set(in_set_q),
    .term_in(term_in),
    .servo_on(fn_d[0]),
    .fwd_inhibit(fn_d[1]),
    .rev_inhibit(fn_d[2]),
    .fwd_enable(fn_d[3]),
    .rev_enable(fn_d[4]),
    .counter_clear(fn_d[5]),
    .fault_clear_request(fn_d[6]),
    .deviation_counter_clear(fn_d[7]),
    .speed_limit_req(fn_d[8]),
    .current_limit_req(fn_d[9]),
    .cmd_source_sel(fn_d[10])
  );

  ////////////////////////////////////////////////////////////////////////
  // Output routing

  logic in_position;

  assign in_position = (deviation_count < inpos_q);

  always_comb begin
    term_out_d = 5'h00;
    term_out_d[1] = !alarm_active;
    unique case (mode_q)
      IOFR_MODE_TRQ: begin
        term_out_d[0] = speed_attained;
        term_out_d[2] = op_ready;
        term_out_d[3] = current_limited_flag;
      end
      default: begin
        term_out_d[0] = (mode_q == IOFR_MODE_POS) ? in_position
                        : speed_attained;
        term_out_d[4] = enc_index;
        unique case (out_set_q)
          2'h1: begin
            term_out_d[2] = op_ready;
            term_out_d[3] = current_limited_flag;
          end
          2'h2: begin
            term_out_d[2] = speed_limited_flag;
            term_out_d[3] = current_limited_flag;
          end
          default: begin
            term_out_d[2] = op_ready;
            term_out_d[3] = speed_limited_flag;
          end
        endcase
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_out_q <= 5'h00;
      fn_q <= 11'h000;
    end else begin
      term_out_q <= term_out_d;
      fn_q <= fn_d;
    end
  end

  assign func_vec = fn_q;
  assign term_out = term_out_q;
  assign servo_on = fn_q[0];
  assign fwd_inhibit = fn_q[1];
  assign rev_inhibit = fn_q[2];
  assign fwd_enable = fn_q[3];
  assign rev_enable = fn_q[4];
  assign counter_clear = fn_q[5];
  assign fault_clear_request = fn_q[6];
  assign deviation_counter_clear = fn_q[7];
  assign speed_limit_req = fn_q[8];
  assign current_limit_req = fn_q[9];
  assign cmd_source_sel = fn_q[10];

endmodule : iofr_router
`default_nettype wire

// File: tb/iofr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module iofr_host_model (
  input wire logic pclk,
  input wire logic [4:0] cmd,
  output logic [4:0] term_in
);
  // Host sets terminals 7..11 just after each edge
  always_ff @(posedge pclk) begin
    term_in <= cmd;
  end
endmodule : iofr_host_model
`default_nettype wire

// File: tb/iofr_router_checker.sv
`timescale 1ns/100ps
`default_nettype none
module iofr_router_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic [4:0] term_in,
  input wire logic [4:0] term_out,
  input wire logic alarm_active,
  input wire logic enc_index,
  input wire logic op_ready,
  input wire logic speed_limited_flag,
  input wire logic current_limited_flag,
  input wire logic servo_on,
  input wire logic fwd_inhibit,
  input wire logic fwd_enable,
  input wire logic rev_inhibit,
  input wire logic rev_enable,
  input wire logic fault_clear_request
);
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic up;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_comb begin
    cnt_d = (cnt_q == 2'h3) ? cnt_q : cnt_q + 2'h1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  assign up = (cnt_q == 2'h3);
  a_alarm_closed: assert property (
    up |-> term_out[1] == !$past(alarm_active)) else $error("alarm out");
  a_servo_fixed: assert property (
    up |-> servo_on == $past(term_in[0])) else $error("servo on");
  a_fwd_source: assert property (
    up && !$past(term_in[1]) |-> !fwd_inhibit && !fwd_enable)
    else $error("forward fn");
  a_rev_source: assert property (
    up && !$past(term_in[2]) |-> !rev_inhibit && !rev_enable)
    else $error("reverse fn");
  a_clear_source: assert property (
    up && !$past(term_in[1]) && !$past(term_in[3]) |-> !fault_clear_request)
    else $error("fault clear");
  a_index_source: assert property (
    up && !$past(enc_index) |-> !term_out[4]) else $error("index out");
  a_middle_source: assert property (
    up && !$past(op_ready) && !$past(speed_limited_flag)
    && !$past(current_limited_flag) |-> term_out[3:2] == 2'h0)
    else $error("outputs 3 4");
  a_pready_wait: assert property (
    psel && penable && !pready |=> pready) else $error("pready late");
  a_pready_pulse: assert property (
    pready |=> !pready) else $error("pready long");
  a_reset_quiet: assert property (
    @(posedge pclk) disable iff (1'b0)
    !presetn |-> term_out == 5'h0 && !servo_on) else $error("reset out");
endmodule : iofr_router_checker
bind iofr_router iofr_router_checker i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .term_in(term_in),
  .term_out(term_out), .alarm_active(alarm_active), .enc_index(enc_index),
  .op_ready(op_ready), .speed_limited_flag(speed_limited_flag),
  .current_limited_flag(current_limited_flag), .servo_on(servo_on),
  .fwd_inhibit(fwd_inhibit), .fwd_enable(fwd_enable),
  .rev_inhibit(rev_inhibit), .rev_enable(rev_enable),
  .fault_clear_request(fault_clear_request));
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin \
  failures++; $display("Error %s expected %h seen %h", nm, ex, got); end end
module testbench;
  import iofr_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic sa, al, rdy, sl, cl, zi;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, rs, ew;
  logic [31:0] seed = 32'h5252;
  logic [4:0] cmd, term_in, term_out;
  logic [23:0] dev;
  wire logic [10:0] fv;
  int failures = 0;
  int total_checks = 0;
  iofr_router i_iofr_router (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .term_in(term_in),
    .term_out(term_out), .deviation_count(dev), .speed_attained(sa),
    .alarm_active(al), .op_ready(rdy), .speed_limited_flag(sl),
    .current_limited_flag(cl), .enc_index(zi), .servo_on(fv[0]),
    .fwd_inhibit(fv[1]), .rev_inhibit(fv[2]), .fwd_enable(fv[3]),
    .rev_enable(fv[4]), .counter_clear(fv[5]),
    .fault_clear_request(fv[6]), .deviation_counter_clear(fv[7]),
    .speed_limit_req(fv[8]), .current_limit_req(fv[9]),
    .cmd_source_sel(fv[10]));
  iofr_host_model i_iofr_host_model (.pclk(pclk), .cmd(cmd),
    .term_in(term_in));
  always #5 pclk = ~pclk;
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [10:0] exp_func(input logic [1:0] m,
      input logic [2:0] s, input logic [4:0] t);
    logic [10:0] f;
    logic [7:0] p;
    f = '0;
    f[0] = t[0];
    case ({m, s})
      5'h00: p = 8'h67;
      5'h01: p = 8'h58;
      5'h02: p = 8'h59;
      5'h03: p = 8'h89;
      5'h08: p = 8'h68;
      5'h09: p = 8'h69;
      5'h0a: p = 8'h89;
      5'h0b: p = 8'h6a;
      5'h0c: p = 8'ha8;
      5'h10: p = 8'h69;
      5'h11: p = 8'h6a;
      default: p = 8'ha9;
    endcase
    if ({m, s} == 5'h03) begin
      f[6] = t[1];
      f[7] = t[2];
    end else begin
      f[m == 2'h0 ? 1 : 3] = t[1];
      f[m == 2'h0 ? 2 : 4] = t[2];
    end
    f[p[7:4]] = t[3];
    f[p[3:0]] = t[4];
    return f;
  endfunction : exp_func
  function automatic logic [4:0] exp_out(input logic [1:0] m,
      input logic [1:0] s, input logic [5:0] st);
    logic [4:0] o;
    o[0] = (m == 2'h0) ? (dev < 24'h5) : st[5];
    o[1] = !st[4];
    o[2] = (s == 2'h2 && m != 2'h2) ? st[2] : st[3];
    o[3] = (s == 2'h0 && m != 2'h2) ? st[2] : st[1];
    o[4] = (m == 2'h2) ? 1'b0 : st[0];
    return o;
  endfunction : exp_out
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task report_and_stop();
    $display("Checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    report_and_stop();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, cmd, dev} = '0;
    {sa, al, rdy, sl, cl, zi} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b0, IOFR_OFS_CTRL, '0);
    `CHK("ctrl reset", 32'h0, rd)
    apb(1'b0, IOFR_OFS_INPOS, '0);
    `CHK("inpos reset", {8'h0, IOFR_INPOS_RST}, rd)
    apb(1'b0, 12'h010, '0);
    `CHK("unmapped err", 1'b1, err)
    apb(1'b1, IOFR_OFS_CTRL, 32'h210);
    `CHK("torque out1 err", 1'b1, err)
    apb(1'b1, IOFR_OFS_CTRL, 32'h4);
    `CHK("position in4 err", 1'b1, err)
    apb(1'b0, IOFR_OFS_CTRL, '0);
    `CHK("ctrl kept", 32'h0, rd)
    apb(1'b1, IOFR_OFS_INPOS, 32'h5);
    apb(1'b1, IOFR_OFS_TERM, 32'h1f);
    `CHK("term write err", 1'b1, err)
    for (int m = 0; m < 3; m++) begin
      for (int s = 0; s < 6; s++) begin
        for (int o = 0; o < 3; o++) begin
          if (s <= (m == 0 ? 3 : m == 1 ? 5 : 2) && o <= (m == 2 ? 0 : 2)) begin
            apb(1'b1, IOFR_OFS_CTRL, {22'h0, 2'(m), 2'h0, 2'(o), 1'h0, 3'(s)});
            `CHK("ctrl err", 1'b0, err)
            repeat (6) begin
              rs = rnd();
              cmd <= rs[4:0];
              {sa, al, rdy, sl, cl, zi} <= rs[10:5];
              dev <= {21'h0, rs[13:11]} + 24'h2;
              repeat (4) @(posedge pclk);
              `CHK("functions", exp_func(2'(m), 3'(s), cmd), fv)
              `CHK("outputs", exp_out(2'(m), 2'(o), rs[10:5]), term_out)
            end
            apb(1'b0, IOFR_OFS_FUNC, '0);
            ew = {21'h0, exp_func(2'(m), 3'(s), cmd)};
            `CHK("func word", ew, rd)
            apb(1'b0, IOFR_OFS_TERM, '0);
            ew = {22'h0, exp_out(2'(m), 2'(o), rs[10:5]), cmd};
            `CHK("term word", ew, rd)
          end
        end
      end
    end
    // Second reset after configuration must restore the defaults
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b0, IOFR_OFS_CTRL, '0);
    `CHK("ctrl rearm", 32'h0, rd)
    apb(1'b0, IOFR_OFS_INPOS, '0);
    `CHK("inpos rearm", {8'h0, IOFR_INPOS_RST}, rd)
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
